// File: port_phy_control_status_regs_test.sv
`timescale 1ns/100ps
`default_nettype none
module port_phy_control_status_regs_test;
  import port_phy_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, spd, dup, fail, pol;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] offer;
  wire [3:0] led_raw, leds;
  phy_stat_t phy_stat;
  phy_ctrl_t phy_ctrl;
  int errors, n_compared;
  port_phy_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .phy_stat(phy_stat),
    .led_raw(led_raw), .phy_ctrl(phy_ctrl), .resolved_speed_100(spd), .resolved_full_duplex(dup),
    .port1_led_3(leds[3]), .port1_led_2(leds[2]), .port1_led_1(leds[1]), .port1_led_0(leds[0]));
  port_phy_partner peer (.pclk(pclk), .presetn(presetn), .phy_ctrl(phy_ctrl), .offer(offer), .fail(fail),
    .pol(pol), .phy_stat(phy_stat), .led_raw(led_raw));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic t_reset();
    apb(1'b0, CTRL_ADDR, '0);
    chk("ctrl reset", 32'h0000_00FF, rd);
    apb(1'b0, STAT_ADDR, '0);
    chk("stat reset", 32'h0000_8000, rd);
    $display("reset test done");
  endtask
  task automatic t_ctrl();
    apb(1'b1, CTRL_ADDR, 32'h0000_FFFF);
    apb(1'b0, CTRL_ADDR, '0);
    chk("ctrl readback", 32'h0000_CFFF, rd);
    chk("ctrl outputs set", 32'h0000_5FFF, 32'(phy_ctrl));
    chk("power down", 32'h1, 32'(phy_ctrl.power_down));
    chk("far loopback", 32'h1, 32'(phy_ctrl.far_end_loopback));
    chk("leds blank", 32'h0000_000F, 32'(leds));
    apb(1'b1, CTRL_ADDR, 32'h0000_0200);
    repeat (2) @(posedge pclk);
    chk("ctrl outputs clear", 32'h0000_0080, 32'(phy_ctrl));
    chk("leds normal", 32'(led_raw), 32'(leds));
    $display("control test done");
  endtask
  task automatic t_forced();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CTRL_ADDR, 32'(i) << 5);
      apb(1'b0, STAT_ADDR, '0);
      chk("forced speed duplex", 32'(i), 32'(rd[10:9]));
      chk("resolved outputs", 32'(i), 32'({spd, dup}));
      chk("status speed", 32'(i >> 1), 32'(rd[10]));
      chk("status duplex", 32'(i & 1), 32'(rd[9]));
    end
    $display("forced test done");
  endtask
  task automatic t_an();
    offer <= 5'h1F;
    pol <= 1'b1;
    apb(1'b1, CTRL_ADDR, 32'h0000_209F);
    repeat (6) @(posedge pclk);
    apb(1'b0, STAT_ADDR, '0);
    chk("negotiated status", 32'h0000_BE7F, rd);
    chk("polarity", 32'h1, 32'(rd[13]));
    chk("partner abilities", 32'h1F, 32'(rd[4:0]));
    offer <= 5'h04;
    fail <= 1'b1;
    pol <= 1'b0;
    apb(1'b1, CTRL_ADDR, 32'h0000_20BF);
    repeat (6) @(posedge pclk);
    apb(1'b0, STAT_ADDR, '0);
    chk("failed status", 32'h0000_8604, rd);
    apb(1'b1, STAT_ADDR, '0);
    apb(1'b0, STAT_ADDR, '0);
    chk("algorithm select", 32'h0000_0604, rd);
    $display("negotiation test done");
  endtask
  task automatic t_bad();
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    chk("write refused", 32'h1, 32'(err));
    apb(1'b0, 12'h00C, '0);
    chk("read refused", 32'h0000_0000, rd);
    apb(1'b0, CTRL_ADDR, '0);
    chk("ctrl kept", 32'h0000_00BF, rd);
    $display("refusal test done");
  endtask
  initial begin
    {presetn, psel, penable, pwrite, fail, pol, paddr, pwdata, offer} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ctrl();
    t_forced();
    t_an();
    t_bad();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// File: port_phy_partner.sv
`timescale 1ns/100ps
`default_nettype none
module port_phy_partner
  import port_phy_pkg::*;
(
  // Control from the block and the far end's offer
  input wire logic pclk,
  input wire logic presetn,
  input wire phy_ctrl_t phy_ctrl,
  input wire logic [4:0] offer,
  input wire logic fail,
  input wire logic pol,
  // Status back to the block
  output var phy_stat_t phy_stat,
  output logic [3:0] led_raw
);
  logic [2:0] cnt_reg;
  logic [4:0] common;
  // Only abilities both ends advertise can be resolved.
  assign common = offer & phy_ctrl.advertise;
  assign led_raw = {2'b10, ~phy_stat.link_good, ~phy_stat.an_done};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 3'h0;
      phy_stat <= '0;
    end else if (phy_ctrl.an_restart) begin
      cnt_reg <= 3'h4;
      phy_stat <= '0;
    end else if (cnt_reg == 3'h1) begin
      cnt_reg <= 3'h0;
      phy_stat <= '{pol, common[4] & !fail, common[4] & !fail, phy_ctrl.force_mdix, !fail, fail, !fail,
                    |common[3:2], common[3] | common[1], offer};
    end else if (cnt_reg != 3'h0) begin
      cnt_reg <= cnt_reg - 3'h1;
    end
  end
endmodule
`default_nettype wire

// File: port_phy_pkg.sv
package port_phy_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  // Printed offsets are register indices; byte address is four times the index.
  localparam logic [7:0] CTRL_INDEX = 8'h02;
  localparam logic [7:0] STAT_INDEX = 8'h04;
  localparam logic [11:0] CTRL_ADDR = 12'h008;
  localparam logic [11:0] STAT_ADDR = 12'h010;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CTRL_LED_OFF = 15;
  localparam int CTRL_TX_DIS = 14;
  localparam int CTRL_AN_RESTART = 13;
  localparam int CTRL_POWER_DOWN = 11;
  localparam int CTRL_MDIX_DIS = 10;
  localparam int CTRL_FORCE_MDIX = 9;
  localparam int CTRL_FAR_LOOP = 8;
  localparam int CTRL_AN_EN = 7;
  localparam int CTRL_SPEED = 6;
  localparam int CTRL_DUPLEX = 5;
  localparam int ADV_LSB = 0;
  localparam int ADV_MSB = 4;
  localparam logic [15:0] CTRL_RESET = 16'h00FF;
  // Bit 12 is reserved and 13 self-clears, so neither is stored.
  localparam logic [15:0] CTRL_WMASK = 16'hCFFF;

  // ****************************************************************
  // Status register fields
  // ****************************************************************
  localparam int STAT_XOVER_ALGO = 15;
  localparam int STAT_POLARITY = 13;
  localparam int STAT_RX_FC = 12;
  localparam int STAT_TX_FC = 11;
  localparam int STAT_SPEED = 10;
  localparam int STAT_DUPLEX = 9;
  localparam int STAT_MDIX = 7;
  localparam int STAT_AN_DONE = 6;
  localparam int STAT_LINK = 5;
  localparam logic STAT_ALGO_RESET = 1'b1;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic tx_disable;
    logic an_restart;
    logic power_down;
    logic auto_mdix_disable;
    logic force_mdix;
    logic far_end_loopback;
    logic an_enable;
    logic crossover_algorithm_select;
    logic [4:0] advertise;
    logic speed_100;
    logic full_duplex;
  } phy_ctrl_t;

  typedef struct packed {
    logic polarity_reversed;
    logic rx_fc_active;
    logic tx_fc_active;
    logic mdix_active;
    logic an_done;
    logic an_failed;
    logic link_good;
    logic an_speed_100;
    logic an_full_duplex;
    logic [4:0] partner_abilities;
  } phy_stat_t;

endpackage

// File: port_phy_regs.sv
// Function
// - LED off bit drives all LEDs high
// - Transmit disable bit stops the transmitter
// - Writing one restarts auto-negotiation
// - Bit ten disables automatic crossover detection
// - Bit nine forces crossed mode when disabled
// - Bit eight enables far-end loopback
// - Negotiation disabled takes speed, duplex from bits
// - Forced speed: one 100, zero 10
// - Forced duplex: one full, zero half
// - Failed negotiation takes duplex from bit five
// - Bits four to zero select advertised abilities
// - Writable status bit selects crossover algorithm
// - Status bit thirteen shows reversed polarity
// - Status bits twelve, eleven show flow control
// - Status bit ten shows resolved speed
// - Status bit nine shows resolved duplex
// - Status bits four to zero show partner abilities
`timescale 1ns/100ps
`default_nettype none

module port_phy_regs
  import port_phy_pkg::*;
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PHY side
  input wire phy_stat_t phy_stat,
  input wire logic [3:0] led_raw,
  output phy_ctrl_t phy_ctrl,
  output logic resolved_speed_100,
  output logic resolved_full_duplex,
  // LED pins
  output logic port1_led_3,
  output logic port1_led_2,
  output logic port1_led_1,
  output logic port1_led_0
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic [15:0] ctrl_reg;
  logic algo_reg;
  logic restart_reg;
  logic speed_reg;
  logic duplex_reg;
  logic [3:0] led_reg;
  logic [15:0] stat_value;
  logic setup;
  logic access;
  logic hit_ctrl;
  logic hit_stat;
  logic speed_next;
  logic duplex_next;
  logic force_mdix_reg;

  assign setup = psel & ~penable;
  // A write lands only on the edge where the registered ready is seen.
  assign access = psel & penable & pready;
  assign hit_ctrl = (paddr == CTRL_ADDR);
  assign hit_stat = (paddr == STAT_ADDR);

  // ****************************************************************
  // Bus answer
  // ****************************************************************
  // Ready is registered, so every access takes exactly one wait-free access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit_ctrl & ~hit_stat;
      if (setup & ~pwrite & hit_ctrl) begin
        prdata <= {16'h0000, ctrl_reg};
      end else if (setup & ~pwrite & hit_stat) begin
        prdata <= {16'h0000, stat_value};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (access & pwrite & hit_ctrl) begin
      ctrl_reg <= pwdata[15:0] & CTRL_WMASK;
    end
  end

  // The restart request is a one-cycle pulse; the bit reads back as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= access & pwrite & hit_ctrl & pwdata[CTRL_AN_RESTART];
    end
  end

  // Forced crossover has its own flop, loaded with the control word, so the output has no gate behind it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_mdix_reg <= 1'b0;
    end else if (access & pwrite & hit_ctrl) begin
      force_mdix_reg <= pwdata[CTRL_MDIX_DIS] & pwdata[CTRL_FORCE_MDIX];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      algo_reg <= STAT_ALGO_RESET;
    end else if (access & pwrite & hit_stat) begin
      algo_reg <= pwdata[STAT_XOVER_ALGO];
    end
  end

  // ****************************************************************
  // Speed and duplex resolution
  // ****************************************************************
  // A failed negotiation still reports the sensed speed; duplex comes from control bit five.
  always_comb begin
    if (!ctrl_reg[CTRL_AN_EN]) begin
      speed_next = ctrl_reg[CTRL_SPEED];
      duplex_next = ctrl_reg[CTRL_DUPLEX];
    end else if (phy_stat.an_failed) begin
      speed_next = phy_stat.an_speed_100;
      duplex_next = ctrl_reg[CTRL_DUPLEX];
    end else begin
      speed_next = phy_stat.an_speed_100;
      duplex_next = phy_stat.an_full_duplex;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_reg <= 1'b0;
      duplex_reg <= 1'b0;
    end else begin
      speed_reg <= speed_next;
      duplex_reg <= duplex_next;
    end
  end

  assign resolved_speed_100 = speed_reg;
  assign resolved_full_duplex = duplex_reg;

  // ****************************************************************
  // Status register
  // ****************************************************************
  always_comb begin
    stat_value = 16'h0000;
    stat_value[STAT_XOVER_ALGO] = algo_reg;
    stat_value[STAT_POLARITY] = phy_stat.polarity_reversed;
    stat_value[STAT_RX_FC] = phy_stat.rx_fc_active;
    stat_value[STAT_TX_FC] = phy_stat.tx_fc_active;
    stat_value[STAT_SPEED] = speed_reg;
    stat_value[STAT_DUPLEX] = duplex_reg;
    stat_value[STAT_MDIX] = phy_stat.mdix_active;
    stat_value[STAT_AN_DONE] = phy_stat.an_done;
    stat_value[STAT_LINK] = phy_stat.link_good;
    stat_value[ADV_MSB:ADV_LSB] = phy_stat.partner_abilities;
  end

  // ****************************************************************
  // PHY controls and LEDs
  // ****************************************************************
  always_comb begin
    phy_ctrl.tx_disable = ctrl_reg[CTRL_TX_DIS];
    phy_ctrl.an_restart = restart_reg;
    phy_ctrl.power_down = ctrl_reg[CTRL_POWER_DOWN];
    phy_ctrl.auto_mdix_disable = ctrl_reg[CTRL_MDIX_DIS];
    phy_ctrl.force_mdix = force_mdix_reg;
    phy_ctrl.far_end_loopback = ctrl_reg[CTRL_FAR_LOOP];
    phy_ctrl.an_enable = ctrl_reg[CTRL_AN_EN];
    phy_ctrl.crossover_algorithm_select = algo_reg;
    phy_ctrl.advertise = ctrl_reg[ADV_MSB:ADV_LSB];
    phy_ctrl.speed_100 = ctrl_reg[CTRL_SPEED];
    phy_ctrl.full_duplex = ctrl_reg[CTRL_DUPLEX];
  end

  // LEDs are active low, so blanking drives every pin high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_reg <= 4'hF;
    end else if (ctrl_reg[CTRL_LED_OFF]) begin
      led_reg <= 4'hF;
    end else begin
      led_reg <= led_raw;
    end
  end

  assign port1_led_3 = led_reg[3];
  assign port1_led_2 = led_reg[2];
  assign port1_led_1 = led_reg[1];
  assign port1_led_0 = led_reg[0];

endmodule

`default_nettype wire

// File: port_phy_regs_chk.sv
`timescale 1ns/100ps
`default_nettype none
module port_phy_regs_chk
  import port_phy_pkg::*;
(
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // PHY side and LEDs
  input wire phy_stat_t phy_stat,
  input wire logic [3:0] led_raw,
  input wire phy_ctrl_t phy_ctrl,
  input wire logic resolved_speed_100,
  input wire logic resolved_full_duplex,
  input wire logic port1_led_3,
  input wire logic port1_led_2,
  input wire logic port1_led_1,
  input wire logic port1_led_0
);
  logic rd_stat;
  logic [3:0] leds;
  assign rd_stat = pready && !pwrite && paddr == STAT_ADDR;
  assign leds = {port1_led_3, port1_led_2, port1_led_1, port1_led_0};
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_pready_after_setup: assert property (psel && !penable |=> pready && penable)
    else $error("no access cycle after setup");
  a_pready_only_access: assert property (pready |-> $past(psel && !penable))
    else $error("stray pready");
  a_unmapped_err: assert property (pready && paddr != CTRL_ADDR && paddr != STAT_ADDR |-> pslverr && prdata == '0)
    else $error("unmapped access not refused");
  a_led_follow: assert property (leds != 4'hF |-> leds == $past(led_raw))
    else $error("leds not following raw levels");
  a_restart_pulse: assert property (phy_ctrl.an_restart |-> $past(pready && pwrite && paddr == CTRL_ADDR && pwdata[13]) ##1 !phy_ctrl.an_restart)
    else $error("bad restart pulse");
  a_mdix_force: assert property (phy_ctrl.force_mdix |-> phy_ctrl.auto_mdix_disable)
    else $error("crossed mode forced while automatic");
  a_speed_resolve: assert property ($past(presetn) |-> resolved_speed_100 == ($past(phy_ctrl.an_enable) ? $past(phy_stat.an_speed_100) : $past(phy_ctrl.speed_100)))
    else $error("wrong resolved speed");
  a_duplex_resolve: assert property ($past(presetn) |-> resolved_full_duplex == ($past(phy_ctrl.an_enable && !phy_stat.an_failed) ? $past(phy_stat.an_full_duplex) : $past(phy_ctrl.full_duplex)))
    else $error("wrong resolved duplex");
  a_stat_fields: assert property (rd_stat |-> prdata[13:11] == $past({phy_stat.polarity_reversed, phy_stat.rx_fc_active, phy_stat.tx_fc_active}) && prdata[7:0] == $past({phy_stat.mdix_active, phy_stat.an_done, phy_stat.link_good, phy_stat.partner_abilities}))
    else $error("status fields wrong");
  c_restart: cover property (phy_ctrl.an_restart);
  c_done_read: cover property (rd_stat && prdata[6]);
  c_refused: cover property (pslverr);
endmodule
bind port_phy_regs port_phy_regs_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .phy_stat(phy_stat), .led_raw(led_raw), .phy_ctrl(phy_ctrl), .resolved_speed_100(resolved_speed_100),
  .resolved_full_duplex(resolved_full_duplex), .port1_led_3(port1_led_3), .port1_led_2(port1_led_2),
  .port1_led_1(port1_led_1), .port1_led_0(port1_led_0));
`default_nettype wire
